// [pkg/psp_pkg.sv]
package psp_pkg;
  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned RATE_COUNT = 6;
  localparam int unsigned RATE_BPS [RATE_COUNT] = '{4800, 9600, 19200, 38400, 57600, 115200};
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned TURN_WAIT_MS = 5;
  localparam int unsigned TURN_WAIT_CYC = (CLK_HZ / 1000) * TURN_WAIT_MS;
  localparam int unsigned MSG_MAX_BYTES = 1024;
  localparam int unsigned GAP_BITS = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIFO_DEPTH = 16;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PSP_PAR_NONE = 2'b00,
    PSP_PAR_EVEN = 2'b01,
    PSP_PAR_ODD = 2'b10
  } psp_parity_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } psp_byte_t;

  typedef struct packed {
    logic parityErr;
    logic sumErr;
    logic overrunErr;
    logic framingErr;
    logic lengthErr;
  } psp_err_t;

  typedef enum logic [1:0] {
    PSP_TX_IDLE = 2'b00,
    PSP_TX_WAIT = 2'b01,
    PSP_TX_SHIFT = 2'b10
  } psp_txst_t;

  typedef enum logic [1:0] {
    PSP_RX_IDLE = 2'b00,
    PSP_RX_START = 2'b01,
    PSP_RX_DATA = 2'b10,
    PSP_RX_STOP = 2'b11
  } psp_rxst_t;
endpackage

// [rtl/psp_fifo.sv]
`timescale 1ns/10ps
module psp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Write side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Read side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_q;
  logic [AW:0] rdPtr_q;
  logic [AW:0] fill;

  assign fill = wrPtr_q - rdPtr_q;
  assign inReady = (fill < (AW+1)'(DEPTH));
  assign outValid = (fill != '0);
  assign outData = mem[rdPtr_q[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (inValid && inReady) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (inValid && inReady) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (outValid && outReady) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule

// [rtl/psp_uart.sv]
`timescale 1ns/10ps
// Summary of operation
// RQ1 - Six line rates, 4800 to 115200 bps, select bit timing.
// RQ2 - Characters go out and come in bit-serially on a single line.
// RQ3 - Least significant bit first; receiver assembles in that order.
// RQ4 - Flag parity, sum, overrun and framing errors on receive.
// RQ5 - Messages of variable length; boundaries tracked both ways.
// RQ6 - Messages are at most 1024 bytes; longer received ones are flagged.
// RQ7 - Terminal-ready output high while the port can communicate.
// RQ8 - Peer is ready only while peer-ready input is high.
// RQ9 - Receive-ready high only while incoming data can be accepted.
// RQ10 - Wait a turnaround time after last receive before transmitting.
// RQ11 - Half duplex, each character framed by start and stop bits.
module psp_uart #(
  parameter int unsigned TURN_CYC = psp_pkg::TURN_WAIT_CYC,
  parameter int unsigned MAX_BYTES = psp_pkg::MSG_MAX_BYTES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Configuration
  input wire logic enable,
  input wire logic [2:0] rateSel,
  input wire psp_pkg::psp_parity_t paritySel,
  input wire logic sumEnable,
  // Transmit message stream
  input wire logic txValid,
  output logic txReady,
  input wire psp_pkg::psp_byte_t txByte,
  // Receive message stream
  output logic rxValid,
  input wire logic rxReady,
  output psp_pkg::psp_byte_t rxByte,
  // Error pulses
  output psp_pkg::psp_err_t rxErr,
  output logic rxMsgEnd,
  // Line pins
  output logic serial_transmit_line,
  input wire logic serial_receive_line,
  output logic terminal_ready_out,
  input wire logic peer_ready_in,
  output logic receive_ready_out
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] rxdSync_q;
  logic [1:0] peerSync_q;
  logic rxd;
  logic peerOk;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rxdSync_q <= 2'b11;
      peerSync_q <= 2'b00;
    end else begin
      rxdSync_q <= {rxdSync_q[0], serial_receive_line};
      peerSync_q <= {peerSync_q[0], peer_ready_in};
    end
  end
  assign rxd = rxdSync_q[1];
  assign peerOk = peerSync_q[1]; // RQ8

  // ------------------------------------------------------------
  // Rate divider: one tick per sixteenth of a bit
  // ------------------------------------------------------------
  function automatic logic [15:0] tickDiv(input logic [2:0] sel);
    int unsigned idx;
    idx = (sel < 3'(psp_pkg::RATE_COUNT)) ? int'(sel) : 0;
    return 16'(psp_pkg::CLK_HZ / (psp_pkg::RATE_BPS[idx] * psp_pkg::OVERSAMPLE));
  endfunction

  logic [15:0] divCnt_q;
  logic tick;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      divCnt_q <= '0;
    end else if (tick) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= divCnt_q + 16'h0001;
    end
  end
  assign tick = (divCnt_q >= tickDiv(rateSel) - 16'h0001); // RQ1

  // ------------------------------------------------------------
  // Receive buffer
  // ------------------------------------------------------------
  logic fifoInValid;
  logic fifoInReady;
  psp_pkg::psp_byte_t fifoInData;
  psp_fifo #(
    .WIDTH(psp_pkg::DATA_W + 1),
    .DEPTH(psp_pkg::FIFO_DEPTH)
  ) uRxFifo (
    .mclk(mclk),
    .rstn(rstn),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData(rxByte)
  );

  assign terminal_ready_out = enable; // RQ7
  assign receive_ready_out = enable && fifoInReady; // RQ9

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  psp_pkg::psp_rxst_t rxSt_q;
  logic [3:0] rxSub_q;
  logic [3:0] rxBit_q;
  logic [7:0] rxShift_q;
  logic [7:0] rxSum_q;
  logic [10:0] rxLen_q;
  logic [4:0] rxGap_q;
  logic rxPar_q;
  logic rxBusy;
  logic rxByteDone;
  logic txBusy;
  logic [3:0] rxDataBits;

  assign rxDataBits = (paritySel == psp_pkg::PSP_PAR_NONE) ? 4'h8 : 4'h9;
  assign rxBusy = (rxSt_q != psp_pkg::PSP_RX_IDLE);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rxSt_q <= psp_pkg::PSP_RX_IDLE;
      rxSub_q <= '0;
      rxBit_q <= '0;
      rxShift_q <= '0;
      rxPar_q <= 1'b0;
    end else if (!enable) begin
      rxSt_q <= psp_pkg::PSP_RX_IDLE;
    end else if (tick) begin
      rxSub_q <= rxSub_q + 4'h1;
      unique case (rxSt_q)
        psp_pkg::PSP_RX_IDLE: begin
          // Sub-bit count keeps running while idle so the message gap can be timed
          if (!rxd && !txBusy) begin // RQ11
            rxSub_q <= '0;
            rxSt_q <= psp_pkg::PSP_RX_START;
          end
        end
        psp_pkg::PSP_RX_START: begin
          if (rxSub_q == 4'h7) begin
            rxSub_q <= '0;
            rxBit_q <= '0;
            rxSt_q <= rxd ? psp_pkg::PSP_RX_IDLE : psp_pkg::PSP_RX_DATA;
          end
        end
        psp_pkg::PSP_RX_DATA: begin
          if (rxSub_q == 4'hf) begin
            if (rxBit_q < 4'h8) begin
              rxShift_q <= {rxd, rxShift_q[7:1]}; // RQ2 RQ3
            end else begin
              rxPar_q <= rxd;
            end
            rxBit_q <= rxBit_q + 4'h1;
            if (rxBit_q == rxDataBits - 4'h1) begin
              rxSt_q <= psp_pkg::PSP_RX_STOP;
            end
          end
        end
        psp_pkg::PSP_RX_STOP: begin
          if (rxSub_q == 4'hf) begin
            rxSt_q <= psp_pkg::PSP_RX_IDLE;
          end
        end
      endcase
    end
  end

  assign rxByteDone = tick && enable && (rxSt_q == psp_pkg::PSP_RX_STOP) && (rxSub_q == 4'hf);

  // Message end is a line gap of a few character times with no start bit
  logic gapEnd;
  assign gapEnd = tick && (rxGap_q == 5'h1) && !rxBusy;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rxGap_q <= '0;
      rxLen_q <= '0;
      rxSum_q <= '0;
    end else if (rxByteDone) begin
      rxGap_q <= 5'(psp_pkg::GAP_BITS * 10);
      rxSum_q <= rxSum_q + rxShift_q;
      if (rxLen_q <= 11'(MAX_BYTES)) begin
        rxLen_q <= rxLen_q + 11'h001;
      end
    end else if (gapEnd) begin // RQ5
      rxGap_q <= '0;
      rxLen_q <= '0;
      rxSum_q <= '0;
    end else if (tick && rxSub_q == 4'hf && rxGap_q != '0 && !rxBusy) begin
      rxGap_q <= rxGap_q - 5'h01;
    end
  end

  logic parExpect;
  assign parExpect = (^rxShift_q) ^ (paritySel == psp_pkg::PSP_PAR_ODD);
  // Sum rule: the last byte of a message is the 8-bit sum of the earlier ones
  assign fifoInData.data = rxShift_q;
  assign fifoInData.last = 1'b0;
  assign fifoInValid = rxByteDone && rxd && (rxLen_q < 11'(MAX_BYTES)); // RQ6

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rxErr <= '0;
      rxMsgEnd <= 1'b0;
    end else begin
      rxErr <= '0;
      rxMsgEnd <= gapEnd;
      if (rxByteDone) begin
        rxErr.parityErr <= (paritySel != psp_pkg::PSP_PAR_NONE) && (rxPar_q != parExpect); // RQ4
        rxErr.framingErr <= !rxd; // RQ4 RQ11
        rxErr.overrunErr <= !fifoInReady; // RQ4
        rxErr.lengthErr <= (rxLen_q >= 11'(MAX_BYTES)); // RQ6
      end
      if (gapEnd && sumEnable) begin
        rxErr.sumErr <= (rxSum_q - rxShift_q) != rxShift_q; // RQ4
      end
    end
  end

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  psp_pkg::psp_txst_t txSt_q;
  logic [10:0] txShift_q;
  logic [3:0] txBits_q;
  logic [3:0] txSub_q;
  logic [31:0] turnCnt_q;
  logic [10:0] txLen_q;
  logic txPar;

  assign txBusy = (txSt_q == psp_pkg::PSP_TX_SHIFT);
  assign txPar = (^txByte.data) ^ (paritySel == psp_pkg::PSP_PAR_ODD);
  // A byte is taken only once the turnaround has expired, so stalling is the back-pressure
  assign txReady = enable && peerOk && !rxBusy && (txSt_q == psp_pkg::PSP_TX_IDLE)
                   && (turnCnt_q == '0); // RQ8 RQ10 RQ11

  // Turnaround timer restarts on every received byte
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      turnCnt_q <= '0;
    end else if (rxByteDone) begin
      turnCnt_q <= TURN_CYC; // RQ10
    end else if (turnCnt_q != '0) begin
      turnCnt_q <= turnCnt_q - 32'h1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      txSt_q <= psp_pkg::PSP_TX_IDLE;
      txShift_q <= '1;
      txBits_q <= '0;
      txSub_q <= '0;
      txLen_q <= '0;
    end else begin
      unique case (txSt_q)
        psp_pkg::PSP_TX_IDLE: begin
          if (txValid && txReady) begin
            // Frame: start, data LSB first, optional parity, stop
            if (paritySel == psp_pkg::PSP_PAR_NONE) begin
              txShift_q <= {2'b11, txByte.data, 1'b0}; // RQ3 RQ11
              txBits_q <= 4'ha;
            end else begin
              txShift_q <= {1'b1, txPar, txByte.data, 1'b0};
              txBits_q <= 4'hb;
            end
            // Length beyond the limit still sends; the count saturates
            if (txByte.last) begin
              txLen_q <= 11'h000; // RQ5
            end else if (txLen_q != 11'(MAX_BYTES)) begin
              txLen_q <= txLen_q + 11'h001; // RQ6
            end
            txSub_q <= '0;
            txSt_q <= psp_pkg::PSP_TX_WAIT;
          end
        end
        psp_pkg::PSP_TX_WAIT: begin
          if (tick) begin
            txSt_q <= psp_pkg::PSP_TX_SHIFT;
          end
        end
        psp_pkg::PSP_TX_SHIFT: begin
          if (tick) begin
            txSub_q <= txSub_q + 4'h1;
            if (txSub_q == 4'hf) begin
              txShift_q <= {1'b1, txShift_q[10:1]}; // RQ2
              txBits_q <= txBits_q - 4'h1;
              if (txBits_q == 4'h1) begin
                txSt_q <= psp_pkg::PSP_TX_IDLE;
              end
            end
          end
        end
        default: txSt_q <= psp_pkg::PSP_TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      serial_transmit_line <= 1'b1;
    end else begin
      serial_transmit_line <= txBusy ? txShift_q[0] : 1'b1;
    end
  end
endmodule

// [dv/psp_uart_props.sv]
`timescale 1ns/10ps
module psp_uart_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Stream side
  input wire logic enable,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic rxValid,
  input wire psp_pkg::psp_byte_t rxByte,
  input wire psp_pkg::psp_err_t rxErr,
  // Line side
  input wire logic serial_transmit_line,
  input wire logic terminal_ready_out,
  input wire logic peer_ready_in,
  input wire logic receive_ready_out
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  property p_term_rdy;
    terminal_ready_out == enable;
  endproperty
  a_term_rdy: assert property (p_term_rdy) else $error("terminal ready wrong");
  property p_rx_rdy;
    !enable |-> !receive_ready_out;
  endproperty
  a_rx_rdy: assert property (p_rx_rdy) else $error("receive ready while off");
  property p_tx_off;
    !enable |-> !txReady;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx ready while off");
  // Four samples cover the two-stage synchroniser on the peer line
  property p_peer;
    !peer_ready_in [*4] |-> !txReady;
  endproperty
  a_peer: assert property (p_peer) else $error("tx ready with peer absent");
  property p_idle;
    txReady |-> serial_transmit_line;
  endproperty
  a_idle: assert property (p_idle) else $error("line low while idle");
  // Start bit must follow a taken byte within one slowest-rate bit time plus two cycles
  localparam int START_LIMIT = psp_pkg::OVERSAMPLE
    * (psp_pkg::CLK_HZ / (psp_pkg::RATE_BPS[0] * psp_pkg::OVERSAMPLE)) + 2;
  logic [15:0] startWait_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      startWait_q <= '0;
    end else if (txValid && txReady) begin
      startWait_q <= 16'h0001;
    end else if (!serial_transmit_line) begin
      startWait_q <= '0;
    end else if (startWait_q != '0) begin
      startWait_q <= startWait_q + 16'h0001;
    end
  end
  property p_start;
    startWait_q <= 16'(START_LIMIT);
  endproperty
  a_start: assert property (p_start) else $error("no start bit");
  property p_turn;
    $rose(rxValid) |-> !txReady [*8];
  endproperty
  a_turn: assert property (p_turn) else $error("no turnaround wait");
  property p_err_pulse;
    rxErr != '0 |=> rxErr == '0;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error not a pulse");
  property p_last;
    rxValid |-> !rxByte.last;
  endproperty
  a_last: assert property (p_last) else $error("rx last flag set");
endmodule
bind psp_uart psp_uart_props u_props (.mclk(mclk), .rstn(rstn), .enable(enable),
  .txValid(txValid), .txReady(txReady), .rxValid(rxValid), .rxByte(rxByte), .rxErr(rxErr),
  .serial_transmit_line(serial_transmit_line), .terminal_ready_out(terminal_ready_out),
  .peer_ready_in(peer_ready_in), .receive_ready_out(receive_ready_out));

// [dv/psp_host_model.sv]
`timescale 1ns/10ps
module psp_host_model #(
  parameter int BIT = 1736
) (
  // Clock
  input wire logic mclk,
  // Line side
  input wire logic txLine,
  output logic rxLine,
  output logic peerReady
);
  initial begin
    rxLine = 1'b1;
    peerReady = 1'b1;
  end
  task automatic set_peer(input logic v);
    peerReady <= v;
  endtask
  // Messages of a few characters stay far below the limit
  task automatic send_char(input logic [7:0] d, input logic badPar, input logic badStop);
    logic [10:0] f;
    f = {~badStop, (^d) ^ badPar, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxLine <= f[i];
      // A low stop bit is cut short so it is not taken for a new start bit
      repeat ((i == 10 && badStop) ? (BIT * 3) / 4 : BIT) @(posedge mclk);
    end
    rxLine <= 1'b1;
  endtask
  // Samples mid-bit; drift of a few cycles per bit stays well inside
  task automatic grab(output logic ok, output logic [10:0] f);
    ok = 1'b0;
    f = '0;
    for (int i = 0; i < 2000 && !ok; i++) begin
      @(negedge mclk);
      ok = !txLine;
    end
    if (ok) begin
      repeat (BIT / 2) @(posedge mclk);
      for (int i = 0; i < 11; i++) begin
        f[i] = txLine;
        if (i < 10) repeat (BIT) @(posedge mclk);
      end
    end
  endtask
endmodule

// [dv/psp_uart_test.sv]
`timescale 1ns/10ps
module psp_uart_test;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic enable = 1'b1;
  logic [2:0] rateSel = 3'h5;
  psp_pkg::psp_parity_t paritySel = psp_pkg::PSP_PAR_EVEN;
  logic sumEnable = 1'b0;
  logic txValid = 1'b0;
  logic txReady;
  psp_pkg::psp_byte_t txByte = '0;
  logic rxValid;
  logic rxReady = 1'b1;
  psp_pkg::psp_byte_t rxByte;
  psp_pkg::psp_err_t rxErr;
  psp_pkg::psp_err_t errSeen = '0;
  logic endSeen = 1'b0;
  logic rxMsgEnd, txLine, rxLine, termRdy, peerReady, rcvRdy;
  int errorCnt = 0;
  int nChecks = 0;
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (rstn) errSeen <= errSeen | rxErr;
  always @(posedge mclk) if (rstn && rxMsgEnd) endSeen <= 1'b1;
  // ------------------------------------------------------------
  // Design and far side
  // ------------------------------------------------------------
  psp_uart #(.TURN_CYC(100)) u_dut (.mclk(mclk), .rstn(rstn), .enable(enable),
    .rateSel(rateSel), .paritySel(paritySel), .sumEnable(sumEnable), .txValid(txValid),
    .txReady(txReady), .txByte(txByte), .rxValid(rxValid), .rxReady(rxReady),
    .rxByte(rxByte), .rxErr(rxErr), .rxMsgEnd(rxMsgEnd), .serial_transmit_line(txLine),
    .serial_receive_line(rxLine), .terminal_ready_out(termRdy),
    .peer_ready_in(peerReady), .receive_ready_out(rcvRdy));
  psp_host_model #(.BIT(1736)) u_host (.mclk(mclk), .txLine(txLine), .rxLine(rxLine),
    .peerReady(peerReady));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finishTest();
    if (errorCnt == 0 && nChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // A wait that runs out counts as a mismatch; the run still ends in one place
  task automatic tmo();
    cmp(16'h0000, 16'h0001);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_enable();
    @(posedge mclk) enable <= 1'b0;
    @(negedge mclk) cmp({termRdy, rcvRdy, txReady}, 3'h0);
    @(posedge mclk) enable <= 1'b1;
    @(negedge mclk) cmp({termRdy, rcvRdy}, 2'h3);
  endtask
  // Odd parity on transmit; peer drops first so the synchroniser settles before the offer
  task automatic t_tx();
    logic ok;
    logic [10:0] f;
    @(posedge mclk) paritySel <= psp_pkg::PSP_PAR_ODD;
    u_host.set_peer(1'b0);
    repeat (4) @(posedge mclk);
    txByte <= '{data: 8'ha5, last: 1'b1};
    txValid <= 1'b1;
    repeat (10) @(negedge mclk);
    cmp(txReady, 1'b0);
    @(posedge mclk) u_host.set_peer(1'b1);
    for (int i = 0; i < 2000 && txReady !== 1'b1; i++) @(negedge mclk);
    if (txReady !== 1'b1) tmo();
    @(posedge mclk) txValid <= 1'b0;
    u_host.grab(ok, f);
    if (!ok) tmo();
    cmp(f, {2'b11, 8'ha5, 1'b0});
  endtask
  task automatic t_rx_good();
    psp_pkg::psp_byte_t b;
    b = '0;
    fork
      u_host.send_char(8'h3c, 1'b0, 1'b0);
      begin
        for (int i = 0; i < 25000 && rxValid !== 1'b1; i++) @(negedge mclk);
        if (rxValid !== 1'b1) tmo();
        b = rxByte;
        cmp(txReady, 1'b0);
      end
    join
    cmp(b, {8'h3c, 1'b0});
    cmp(errSeen, 5'h00);
    cmp(txReady, 1'b1);
  endtask
  // Bad parity and a low stop bit in one character, closing the same message
  task automatic t_rx_bad();
    u_host.send_char(8'h5a, 1'b1, 1'b1);
    cmp(errSeen, 5'h12);
    cmp(rxValid, 1'b0);
    cmp(endSeen, 1'b0);
  endtask
  // Last byte is not the sum of the earlier one, so the gap end flags a sum error
  task automatic t_msg_end();
    for (int i = 0; i < 60000 && endSeen !== 1'b1; i++) @(negedge mclk);
    cmp(endSeen, 1'b1);
    cmp(errSeen, 5'h1a);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk) cmp(txLine, 1'b1);
    t_enable();
    @(posedge mclk) sumEnable <= 1'b1;
    t_rx_good();
    t_rx_bad();
    t_tx();
    t_msg_end();
    finishTest();
  end
endmodule
